// ### src/frame_sync_defines.vh
/*
  Constants for the frame-synchronisation pulse port: pulse widths and
  frame period as times and as cycle counts, multiframe length in frames.
  Assumes the including module runs on a 10 MHz clock.
*/
// Notes on behaviour
// - Frame number zero modulo 256 has a 2 to 5 ms pulse, seen as marker.
// - Each reference falling edge starts a radio frame, giving 10 ms frames.
// - Marker falling edge restarts the 256-frame multiframe at frame number zero.
// - Falling edge to frame start takes no more than 500 ns.
// - Frame timing follows the reference only once the input is valid.
// - While input is valid, the same pulse train is repeated on the output.
`ifndef FRAME_SYNC_DEFINES_VH
`define FRAME_SYNC_DEFINES_VH

`define FS_CLK_HZ          10000000
`define FS_SHORT_MIN_NS    5000
`define FS_SHORT_MAX_NS    1000000
`define FS_LONG_MIN_NS     2000000
`define FS_LONG_MAX_NS     5000000
`define FS_FRAME_NS        10000000
`define FS_PERIOD_TOL_NS   100000
`define FS_LATENCY_NS      500
// Least times round up, longest times round down.
`define FS_CYC_UP(ns)      ((((ns) * 64'd10) + 64'd999) / 64'd1000)
`define FS_CYC_DN(ns)      (((ns) * 64'd10) / 64'd1000)
`define FS_SHORT_MIN_CYC   `FS_CYC_UP(`FS_SHORT_MIN_NS)
`define FS_SHORT_MAX_CYC   `FS_CYC_DN(`FS_SHORT_MAX_NS)
`define FS_LONG_MIN_CYC    `FS_CYC_UP(`FS_LONG_MIN_NS)
`define FS_LONG_MAX_CYC    `FS_CYC_DN(`FS_LONG_MAX_NS)
`define FS_FRAME_CYC       `FS_CYC_DN(`FS_FRAME_NS)
`define FS_TOL_CYC         `FS_CYC_DN(`FS_PERIOD_TOL_NS)
`define FS_LATENCY_CYC     `FS_CYC_DN(`FS_LATENCY_NS)
`define FS_FRAMES_PER_MF   256
`define FS_GOOD_PULSES     3

`endif

// ### src/pulse_sync.v
/*
  Two-stage synchroniser for one level from outside the clock domain.
  Assumes clk is free running and rst_b is asynchronous active low.
*/
`timescale 1ns/1ps
`default_nettype none
module pulse_sync (
  input  wire clk,
  input  wire rst_b,
  input  wire clk_en,
  input  wire d_in,
  output reg  q_out
);
  reg meta_r;

  // First stage is read only by the second stage.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      q_out  <= 1'b0;
    end else if (clk_en) begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### src/frame_sync_pulse_port.v
/*
  Frame-synchronisation pulse port: measures the incoming reference
  pulses, classifies ordinary and multiframe pulses, declares the input
  valid, aligns local frame timing and regenerates the pulse train.
  Assumes a 10 MHz clock, asynchronous active-low reset and a reference
  pin that is asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frame_sync_defines.vh"
module frame_sync_pulse_port #(
  parameter CNT_W        = 17,
  parameter FRAME_CYC    = `FS_FRAME_CYC,
  parameter SHORT_MIN    = `FS_SHORT_MIN_CYC,
  parameter SHORT_MAX    = `FS_SHORT_MAX_CYC,
  parameter LONG_MIN     = `FS_LONG_MIN_CYC,
  parameter LONG_MAX     = `FS_LONG_MAX_CYC,
  parameter TOL_CYC      = `FS_TOL_CYC,
  parameter GOOD_PULSES  = `FS_GOOD_PULSES
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       clk_en,
  input  wire       sync_in,
  output reg        sync_out,
  output reg        ref_valid,
  output reg        frame_start,
  output reg        multiframe_start,
  output reg  [7:0] cell_frame_number
);
  // Counts are cut to the counter width on purpose; CNT_W must hold the largest one.
  localparam [CNT_W-1:0] FRAME_C  = FRAME_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] SMIN_C   = SHORT_MIN[CNT_W-1:0];
  localparam [CNT_W-1:0] SMAX_C   = SHORT_MAX[CNT_W-1:0];
  localparam [CNT_W-1:0] LMIN_C   = LONG_MIN[CNT_W-1:0];
  localparam [CNT_W-1:0] LMAX_C   = LONG_MAX[CNT_W-1:0];
  localparam [CNT_W-1:0] TOL_C    = TOL_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] PER_LO_C = FRAME_C - TOL_C;
  localparam [CNT_W-1:0] PER_HI_C = FRAME_C + TOL_C;
  localparam [CNT_W-1:0] ONE_C    = 1;
  localparam [3:0]       GOOD_C   = GOOD_PULSES[3:0];

  // Acquisition state codes.
  localparam [1:0] ST_SEARCH = 2'h0;
  localparam [1:0] ST_COUNT  = 2'h1;
  localparam [1:0] ST_LOCKED = 2'h2;

  wire             in_s;
  reg              in_d_r;
  reg  [CNT_W-1:0] width_r;
  reg  [CNT_W-1:0] period_r;
  reg  [1:0]       state_r;
  reg  [1:0]       state_nxt;
  reg  [3:0]       good_r;
  reg  [3:0]       good_nxt;
  reg              marker_seen_r;
  reg              marker_seen_nxt;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and edge detection.

  // The reference pin is brought into the clock domain first.
  pulse_sync u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .clk_en(clk_en),
    .d_in  (sync_in),
    .q_out (in_s)
  );

  wire rise = in_s & ~in_d_r;
  wire fall = ~in_s & in_d_r;

  // Width of the current pulse and time since the last falling edge.
  wire short_ok = (width_r >= SMIN_C) && (width_r <= SMAX_C);
  wire long_ok  = (width_r >= LMIN_C) && (width_r <= LMAX_C);
  wire width_ok = short_ok | long_ok;
  wire per_ok   = (period_r >= PER_LO_C) && (period_r <= PER_HI_C);
  // Pulse stuck high too long or no falling edge inside the period window.
  wire width_bad = in_s && (width_r > LMAX_C);
  wire missing   = (period_r > PER_HI_C);
  wire pulse_err = (fall && (!width_ok || !per_ok)) || width_bad || missing;

  //////////////////////////////////////////////////////////////////////////
  // Measurement counters.

  // Counters saturate so a dead input cannot wrap back into range.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_d_r   <= 1'b0;
      width_r  <= {CNT_W{1'b0}};
      period_r <= {CNT_W{1'b0}};
    end else if (clk_en) begin
      in_d_r <= in_s;
      if (rise)
        width_r <= ONE_C;
      else if (in_s && width_r != {CNT_W{1'b1}})
        width_r <= width_r + ONE_C;
      if (fall)
        period_r <= ONE_C;
      else if (period_r != {CNT_W{1'b1}})
        period_r <= period_r + ONE_C;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Acquisition state machine.

  // Needs GOOD_PULSES well spaced pulses with a marker among them.
  always @* begin
    state_nxt       = state_r;
    good_nxt        = good_r;
    marker_seen_nxt = marker_seen_r;
    case (state_r)
      ST_SEARCH: begin
        good_nxt        = 4'h0;
        marker_seen_nxt = 1'b0;
        if (fall && width_ok) begin
          state_nxt       = ST_COUNT;
          good_nxt        = 4'h1;
          marker_seen_nxt = long_ok;
        end
      end
      ST_COUNT: begin
        if (pulse_err) begin
          state_nxt = ST_SEARCH;
        end else if (fall) begin
          good_nxt        = (good_r == 4'hf) ? good_r : good_r + 4'h1;
          marker_seen_nxt = marker_seen_r | long_ok;
          if (good_nxt >= GOOD_C && marker_seen_nxt)
            state_nxt = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        if (pulse_err)
          state_nxt = ST_SEARCH;
      end
      default: state_nxt = ST_SEARCH;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r       <= ST_SEARCH;
      good_r        <= 4'h0;
      marker_seen_r <= 1'b0;
    end else if (clk_en) begin
      state_r       <= state_nxt;
      good_r        <= good_nxt;
      marker_seen_r <= marker_seen_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame timing and regenerated output.

  // The locking edge itself already counts as aligned.
  wire aligned = (state_nxt == ST_LOCKED);

  // Outputs are all registered; frame start follows the edge within 500 ns.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_out          <= 1'b0;
      ref_valid         <= 1'b0;
      frame_start       <= 1'b0;
      multiframe_start  <= 1'b0;
      cell_frame_number <= 8'h00;
    end else if (clk_en) begin
      ref_valid        <= aligned;
      sync_out         <= aligned & in_s;
      frame_start      <= 1'b0;
      multiframe_start <= 1'b0;
      if (fall && aligned) begin
        frame_start <= 1'b1;
        if (long_ok) begin
          multiframe_start  <= 1'b1;
          cell_frame_number <= 8'h00;
        end else begin
          cell_frame_number <= cell_frame_number + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/frame_sync_pulse_port_properties.sv
/* Port checker for the frame sync block. Assumes a bind to its top. */
`timescale 1ns/1ps
`default_nettype none
module frame_sync_pulse_port_properties (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       clk_en,
  input wire logic       sync_in,
  input wire logic       sync_out,
  input wire logic       ref_valid,
  input wire logic       frame_start,
  input wire logic       multiframe_start,
  input wire logic [7:0] cell_frame_number
);
  // All checks sample on clk and rest while reset is low.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  mf_with_fs_a:
    assert property (multiframe_start |-> frame_start) else $error("lone marker");
  fs_single_a:
    assert property (frame_start |=> !frame_start) else $error("long frame pulse");
  mf_zero_a:
    assert property (multiframe_start |-> cell_frame_number == 8'h00)
      else $error("marker number not zero");
  num_step_a:
    assert property (ref_valid && $past(ref_valid) && frame_start && !multiframe_start
      |-> cell_frame_number == $past(cell_frame_number) + 8'h01) else $error("bad step");
  edge_latency_a:
    assert property (ref_valid && $fell(sync_in) |-> ##[1:5] (frame_start || !ref_valid))
      else $error("frame start late");
  fs_needs_valid_a:
    assert property (frame_start |-> ref_valid) else $error("frame start unlocked");
  out_copy_a:
    assert property (ref_valid && $past(ref_valid, 4) |-> sync_out == $past(sync_in, 3))
      else $error("output not a copy");
  out_quiet_a:
    assert property (!ref_valid && !$past(ref_valid) |-> !sync_out)
      else $error("output while invalid");
endmodule
`default_nettype wire

// ### sim/sync_ref_source.sv
/* Model of the reference source. Assumes the caller spaces the pulses. */
`timescale 1ns/1ps
`default_nettype none
module sync_ref_source (
  input  wire logic clk,
  output var  logic sync_in
);
  initial sync_in = 1'b0;
  // Low, then w clocks high, so each falling edge lands one period after the last.
  // The call returns lead clocks after the falling edge, so the design can answer.
  // The caller picks the long pulses, where a satellite-timed source puts its markers.
  task automatic send(input int w, input int per, input int lead);
    repeat (per - w - lead) @(posedge clk);
    sync_in <= 1'b1;
    repeat (w) @(posedge clk);
    sync_in <= 1'b0;
    repeat (lead) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### sim/frame_sync_pulse_port_tb.sv
/* Bench for the frame sync block. Assumes shortened frame parameters. */
`timescale 1ns/1ps
`default_nettype none
module frame_sync_pulse_port_tb;
  localparam int P = 400; // Frame period in clocks.
  localparam int L = 8;   // Clocks from a falling edge until a pulse call returns.
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       clk_en = 1'b1;
  logic       sync_in, sync_out, ref_valid, frame_start, multiframe_start;
  logic [7:0] cell_frame_number;
  int         errors = 0;
  int         tests_run = 0;
  int         fs_n = 0;
  int         mf_n = 0;
  always #50 clk = ~clk;
  // Counts frame and multiframe starts seen at the port.
  always @(posedge clk) begin
    if (frame_start === 1'b1) fs_n <= fs_n + 1;
    if (multiframe_start === 1'b1) mf_n <= mf_n + 1;
  end
  sync_ref_source src (.clk(clk), .sync_in(sync_in));
  // The long-pulse ceiling keeps its full default; markers here are 150 clocks.
  frame_sync_pulse_port #(.FRAME_CYC(400), .SHORT_MIN(1), .SHORT_MAX(40),
    .LONG_MIN(100), .TOL_CYC(8)) DUT (.clk(clk), .rst_b(rst_b),
    .clk_en(clk_en), .sync_in(sync_in), .sync_out(sync_out), .ref_valid(ref_valid),
    .frame_start(frame_start), .multiframe_start(multiframe_start),
    .cell_frame_number(cell_frame_number));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One pulse of w clocks; returns just after a clock edge, with outputs settled.
  task automatic pl(input int w);
    src.send(w, P, L);
    #1;
  endtask
  // Looks at the output five clocks into a pulse of ten clocks.
  task automatic mid(input logic e);
    fork
      pl(10);
      begin
        repeat (P - 10 - L + 5) @(posedge clk);
        #1;
        chk({7'h0, sync_out}, {7'h0, e});
      end
    join
  endtask
  task automatic t_lock;
    int n;
    int m;
    pl(150);
    pl(10);
    pl(10);
    pl(10);
    chk({7'h0, ref_valid}, 8'h01);
    m = mf_n;
    pl(150);
    chk(cell_frame_number, 8'h00);
    chk(8'(mf_n - m), 8'h01);
    n = fs_n;
    mid(1'b1);
    pl(10);
    pl(10);
    chk(cell_frame_number, 8'h03);
    chk(8'(fs_n - n), 8'h03);
    $display("t_lock done");
  endtask
  task automatic t_bad;
    int n;
    pl(70);
    chk({7'h0, ref_valid}, 8'h00);
    n = fs_n;
    mid(1'b0);
    pl(10);
    pl(10);
    pl(10);
    chk({7'h0, ref_valid}, 8'h00);
    chk(8'(fs_n - n), 8'h00);
    $display("t_bad done");
  endtask
  task automatic t_miss;
    pl(150);
    pl(10);
    pl(10);
    pl(10);
    chk({7'h0, ref_valid}, 8'h01);
    repeat (2 * P) @(posedge clk);
    #1;
    chk({6'h0, ref_valid, sync_out}, 8'h00);
    $display("t_miss done");
  endtask
  // With the enable low for three frames the lock must survive the silence.
  task automatic t_freeze;
    int n;
    pl(150);
    pl(10);
    pl(10);
    n = fs_n;
    @(posedge clk);
    clk_en <= 1'b0;
    repeat (3 * P) @(posedge clk);
    #1;
    chk({7'h0, ref_valid}, 8'h01);
    chk(8'(fs_n - n), 8'h00);
    @(posedge clk);
    clk_en <= 1'b1;
    pl(10);
    chk({7'h0, ref_valid}, 8'h01);
    chk(8'(fs_n - n), 8'h01);
    $display("t_freeze done");
  endtask
  task automatic give_verdict;
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #37;
    chk({4'h0, ref_valid, sync_out, frame_start, multiframe_start}, 8'h00);
    chk(cell_frame_number, 8'h00);
    t_lock;
    t_bad;
    t_miss;
    t_freeze;
    give_verdict;
  end
  // Cuts a hang short.
  initial begin
    #2000000;
    errors++;
    give_verdict;
  end
endmodule
bind frame_sync_pulse_port frame_sync_pulse_port_properties chk_i (.clk(clk),
  .rst_b(rst_b), .clk_en(clk_en), .sync_in(sync_in), .sync_out(sync_out),
  .ref_valid(ref_valid), .frame_start(frame_start),
  .multiframe_start(multiframe_start), .cell_frame_number(cell_frame_number));
`default_nettype wire
